// file: pkg/paging_pkg.sv
// Constants and carriers for data-space paging and EEPROM control
package paging_pkg;
    localparam logic [7:0] WIN_LO        = 8'h40;
    localparam logic [7:0] WIN_HI        = 8'h7F;
    localparam logic [7:0] PAGE_HI       = 8'h3F;
    localparam logic [7:0] WIN_BASE_ADDR = 8'hC9;
    localparam logic [7:0] BANK_ADDR     = 8'hCB;
    localparam logic [7:0] NV_CTL_ADDR   = 8'hDF;
    localparam logic [7:0] BANK_NONE     = 8'h00;
    localparam logic [7:0] BANK_NV0      = 8'h01;
    localparam logic [7:0] BANK_NV1      = 8'h02;
    localparam logic [7:0] BANK_RAM1     = 8'h08;
    localparam logic [7:0] BANK_RAM2     = 8'h10;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam int STANDBY_BIT = 6;
    localparam int START_BIT   = 3;
    localparam int ROWMODE_BIT = 2;
    localparam int BUSY_BIT    = 1;
    localparam int ENABLE_BIT  = 0;
    localparam int OFS_W       = 6;
    localparam int WIN_W       = 6;
    localparam int PM_ADDR_W   = WIN_W + OFS_W;
    localparam int ROW_BYTES   = 8;
    localparam int ROW_SEL_W   = 3;
    localparam int ROW_ADDR_W  = OFS_W + 1 - ROW_SEL_W;
    localparam int PAGE_BYTES  = 64;
    localparam int NV_BYTES    = 2 * PAGE_BYTES;
    localparam int RAM_BYTES   = 2 * PAGE_BYTES;
    localparam int CNT_W       = 16;
    localparam int DEF_PROG_CYCLES = 400;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       rd;
        logic       wr;
    } bus_req_type;

    typedef struct packed {
        logic [7:0] rdata;
        logic       ack;
    } bus_rsp_type;
endpackage

// file: design/data_space_paging.sv
// Data-space window, bank paging and EEPROM programming control
`timescale 1ns/1ps
module data_space_paging
    import paging_pkg::*;
#(
    parameter int PROG_CYCLES = DEF_PROG_CYCLES
) (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire bus_req_type          req,
    output bus_rsp_type               rsp,
    output logic                      hit,
    output logic [PM_ADDR_W-1:0]      pm_addr,
    input  wire logic [7:0]           pm_rdata,
    output logic                      nv_busy_flag
);

    typedef enum logic [1:0] {NV_IDLE, NV_BYTE, NV_ROW} prog_state_type;

    prog_state_type         prog_state_r;
    logic [CNT_W-1:0]       prog_cnt_r;
    logic [WIN_W-1:0]       window_base_bits;
    logic [7:0]             data_bank_select;
    logic                   nv_standby;
    logic                   nv_program_enable;
    logic                   row_mode_enable;
    logic                   row_program_start;
    logic [7:0]             nv_mem [NV_BYTES];
    logic [7:0]             ram_mem [RAM_BYTES];
    logic [7:0]             row_lat_r [ROW_BYTES];
    logic [ROW_BYTES-1:0]   row_mask_r;
    logic [ROW_ADDR_W-1:0]  row_addr_r;
    logic                   row_held_r;
    logic [OFS_W:0]         byte_addr_r;
    logic [7:0]             byte_data_r;
    logic [PM_ADDR_W-1:0]   pm_addr_r;
    logic                   win_pend_r;
    logic [7:0]             rdata_r;
    logic                   ack_r;

    logic in_win, in_page, is_base, is_bank, is_ctl;
    logic nv0_sel, nv1_sel, ram1_sel, ram2_sel, nv_sel, ram_sel;
    logic busy, nv_usable, prog_done;
    logic nv_wr, ctl_wr, byte_go, row_go;
    logic [OFS_W:0] nv_idx, ram_idx;
    logic [ROW_ADDR_W-1:0] acc_row;
    logic [7:0] rd_val;

    // Address decode of the incoming request
    always_comb begin
        in_win  = 1'b0;
        in_page = 1'b0;
        is_base = 1'b0;
        is_bank = 1'b0;
        is_ctl  = 1'b0;
        if (req.addr <= PAGE_HI) begin
            in_page = 1'b1;
        end else if (req.addr >= WIN_LO && req.addr <= WIN_HI) begin
            in_win = 1'b1;
        end else if (req.addr == WIN_BASE_ADDR) begin
            is_base = 1'b1;
        end else if (req.addr == BANK_ADDR) begin
            is_bank = 1'b1;
        end else if (req.addr == NV_CTL_ADDR) begin
            is_ctl = 1'b1;
        end
    end

    // Only the exact one-hot codes open a page; reserved codes open none
    assign nv0_sel  = (data_bank_select == BANK_NV0);
    assign nv1_sel  = (data_bank_select == BANK_NV1);
    assign ram1_sel = (data_bank_select == BANK_RAM1);
    assign ram2_sel = (data_bank_select == BANK_RAM2);
    assign nv_sel   = nv0_sel | nv1_sel;
    assign ram_sel  = ram1_sel | ram2_sel;

    // Page seen at 00h-3Fh with bank-0 style offsets
    assign nv_idx  = {nv1_sel, req.addr[OFS_W-1:0]};
    assign ram_idx = {ram2_sel, req.addr[OFS_W-1:0]};
    assign acc_row = nv_idx[OFS_W:ROW_SEL_W];

    assign busy      = (prog_state_r != NV_IDLE);
    assign nv_usable = !nv_standby && !busy;
    assign prog_done = busy && (prog_cnt_r == '0);
    assign nv_wr     = req.wr && in_page && nv_sel && nv_usable;
    assign ctl_wr    = req.wr && is_ctl && !busy;
    assign byte_go   = nv_wr && !row_mode_enable
                       && nv_program_enable;
    assign row_go    = ctl_wr && req.wdata[START_BIT]
                       && nv_program_enable
                       && row_mode_enable;

    assign hit          = in_win | in_page | is_base | is_bank | is_ctl;
    assign nv_busy_flag = busy;
    assign pm_addr      = pm_addr_r;
    assign rsp          = '{rdata: rdata_r, ack: ack_r};

    // Window base and bank select carry no reset: software restores them
    always_ff @(posedge clock) begin
        if (req.wr && is_base) begin
            window_base_bits <= req.wdata[WIN_W-1:0];
        end
        if (req.wr && is_bank) begin
            data_bank_select <= req.wdata;
        end
    end

    // Control register; every write is dropped while a cycle runs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            nv_standby        <= 1'b0;
            nv_program_enable <= 1'b0;
            row_mode_enable   <= 1'b0;
            row_program_start <= 1'b0;
        end else if (ctl_wr) begin
            nv_standby        <= req.wdata[STANDBY_BIT];
            nv_program_enable <= req.wdata[ENABLE_BIT];
            row_mode_enable   <= req.wdata[ROWMODE_BIT];
            if (row_go) begin
                row_program_start <= 1'b1;
            end
        end else if (prog_done && prog_state_r == NV_ROW) begin
            row_mode_enable   <= 1'b0;
            row_program_start <= 1'b0;
        end
    end

    // Row latches: cleared when row mode is switched on
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            row_mask_r <= '0;
            row_held_r <= 1'b0;
            row_addr_r <= '0;
        end else if (ctl_wr && req.wdata[ROWMODE_BIT]
                     && !row_mode_enable) begin
            row_mask_r <= '0;
            row_held_r <= 1'b0;
        end else if (nv_wr && row_mode_enable
                     && (!row_held_r || acc_row == row_addr_r)) begin
            row_held_r <= 1'b1;
            row_addr_r <= acc_row;
            row_mask_r[nv_idx[ROW_SEL_W-1:0]] <= 1'b1;
        end else if (prog_done && prog_state_r == NV_ROW) begin
            row_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (nv_wr && row_mode_enable
            && (!row_held_r || acc_row == row_addr_r)) begin
            row_lat_r[nv_idx[ROW_SEL_W-1:0]] <= req.wdata;
        end
    end

    // Byte mode target is captured at the store itself
    always_ff @(posedge clock) begin
        if (byte_go) begin
            byte_addr_r <= nv_idx;
            byte_data_r <= req.wdata;
        end
    end

    // Programming cycle timer; its length is a parameter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prog_state_r <= NV_IDLE;
            prog_cnt_r   <= '0;
        end else begin
            case (prog_state_r)
                NV_IDLE: begin
                    if (byte_go) begin
                        prog_state_r <= NV_BYTE;
                        prog_cnt_r   <= CNT_W'(PROG_CYCLES - 1);
                    end else if (row_go) begin
                        prog_state_r <= NV_ROW;
                        prog_cnt_r   <= CNT_W'(PROG_CYCLES - 1);
                    end
                end
                default: begin
                    if (prog_done) begin
                        prog_state_r <= NV_IDLE;
                    end else begin
                        prog_cnt_r <= prog_cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // Cells change at the end of the cycle; unwritten row bytes stay put
    always_ff @(posedge clock) begin
        if (prog_done && prog_state_r == NV_BYTE) begin
            nv_mem[byte_addr_r] <= byte_data_r;
        end
        if (prog_done && prog_state_r == NV_ROW) begin
            for (int i = 0; i < ROW_BYTES; i++) begin
                if (row_mask_r[i]) begin
                    nv_mem[{row_addr_r, ROW_SEL_W'(i)}] <= row_lat_r[i];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (req.wr && in_page && ram_sel) begin
            ram_mem[ram_idx] <= req.wdata;
        end
    end

    // Read value; a void EEPROM access answers zero
    always_comb begin
        rd_val = ZERO_BYTE;
        if (in_page && nv_sel) begin
            if (nv_usable && !row_mode_enable) begin
                rd_val = nv_mem[nv_idx];
            end
        end else if (in_page && ram_sel) begin
            rd_val = ram_mem[ram_idx];
        end else if (is_ctl) begin
            rd_val[BUSY_BIT] = busy;
        end
    end

    // Window reads take one extra cycle for the program-memory fetch
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            win_pend_r <= 1'b0;
            pm_addr_r  <= '0;
            ack_r      <= 1'b0;
            rdata_r    <= ZERO_BYTE;
        end else begin
            win_pend_r <= req.rd && in_win;
            ack_r      <= win_pend_r || (req.rd && hit && !in_win);
            if (req.rd && in_win) begin
                pm_addr_r <= {window_base_bits,
                              req.addr[OFS_W-1:0]};
            end
            if (win_pend_r) begin
                rdata_r <= pm_rdata;
            end else if (req.rd && hit) begin
                rdata_r <= rd_val;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence win_rd_s;
        req.rd && in_win;
    endsequence

    sequence win_answer_s;
        ##1 (pm_addr_r == {$past(window_base_bits),
                           $past(req.addr[OFS_W-1:0])})
        ##1 (ack_r && rdata_r == $past(pm_rdata));
    endsequence

    sequence row_end_s;
        prog_state_r == NV_ROW && prog_done;
    endsequence

    // Helper for busy_span_a: a long stretch is counted, not unrolled
    logic [CNT_W-1:0] busy_len_r;

    always_ff @(posedge clock) begin
        if (sys_rst || !busy) begin
            busy_len_r <= '0;
        end else begin
            busy_len_r <= busy_len_r + 1'b1;
        end
    end

    window_fetch_a: assert property (win_rd_s |-> win_answer_s)
        else $error("window read fetched wrong address or data");

    window_bits_a: assert property (
        req.wr && is_base
        |=> window_base_bits == $past(req.wdata[WIN_W-1:0]))
        else $error("window base lost its six low bits");

    void_regs_a: assert property (
        req.rd && (is_base || is_bank) |=> ack_r && rdata_r == ZERO_BYTE)
        else $error("write-only register read back data");

    empty_bank_a: assert property (
        req.rd && in_page && data_bank_select == BANK_NONE
        |=> ack_r && rdata_r == ZERO_BYTE)
        else $error("unselected page returned data");

    page_time_a: assert property (
        req.rd && in_page |=> ack_r)
        else $error("page load not answered in one cycle");

    standby_read_a: assert property (
        req.rd && in_page && nv_sel && nv_standby
        |=> ack_r && rdata_r == ZERO_BYTE)
        else $error("EEPROM read in standby returned data");

    enable_gate_a: assert property (
        !busy && req.wr && in_page && nv_sel && !nv_program_enable
        && !row_mode_enable |=> !busy)
        else $error("write without enable started a cycle");

    byte_start_a: assert property (
        byte_go |=> prog_state_r == NV_BYTE
        && prog_cnt_r == CNT_W'(PROG_CYCLES - 1))
        else $error("byte store did not start a full cycle");

    busy_span_a: assert property (
        $fell(busy) |-> busy_len_r == CNT_W'(PROG_CYCLES))
        else $error("busy fell before the cycle ended");

    busy_write_a: assert property (
        busy && req.wr && is_ctl
        |=> nv_standby == $past(nv_standby)
        && nv_program_enable == $past(nv_program_enable))
        else $error("control changed while busy");

    status_read_a: assert property (
        req.rd && is_ctl
        |=> rdata_r[BUSY_BIT] == $past(busy) && !rdata_r[STANDBY_BIT])
        else $error("control read gave wrong status");

    start_gate_a: assert property (
        !busy && req.wr && is_ctl && req.wdata[START_BIT]
        && !(nv_program_enable && row_mode_enable)
        |=> !busy && row_program_start == $past(row_program_start))
        else $error("row start taken without enable and row mode");

    row_clear_a: assert property (
        row_end_s |=> !row_mode_enable && !row_program_start && !busy)
        else $error("row mode or start not cleared at cycle end");

    other_row_a: assert property (
        nv_wr && row_mode_enable && row_held_r && acc_row != row_addr_r
        |=> row_mask_r == $past(row_mask_r))
        else $error("store to another row reached the latches");

    latch_clear_a: assert property (
        ctl_wr && req.wdata[ROWMODE_BIT] && !row_mode_enable
        |=> row_mask_r == '0)
        else $error("row latches not cleared on row mode entry");

endmodule

// file: tb/prog_mem_model.sv
// Program-memory model answering data-window fetches
`timescale 1ns/1ps
module prog_mem_model
    import paging_pkg::*;
(
    input  wire logic [PM_ADDR_W-1:0] pm_addr,
    output logic [7:0]                pm_rdata
);
    // Every address bit moves the byte, so a wrong base bit is seen
    assign pm_rdata = pm_addr[7:0]
                      ^ {pm_addr[11:8], pm_addr[11:8]} ^ 8'h5A;
endmodule

// file: tb/data_space_paging_eeprom_ctl_tb.sv
// Self-checking bench for data-space paging and EEPROM control
`timescale 1ns/1ps
module data_space_paging_eeprom_ctl_tb
    import paging_pkg::*;
;
    localparam int PC = 10;
    logic                 clock = 1'b0;
    logic                 sys_rst = 1'b1;
    bus_req_type          req = '0;
    bus_rsp_type          rsp;
    logic                 hit;
    logic                 nv_busy_flag;
    logic [PM_ADDR_W-1:0] pm_addr;
    logic [7:0]           pm_rdata;
    logic [7:0]           a;
    logic [7:0]           d;
    logic [7:0]           base;
    logic [7:0]           e;
    logic [7:0]           row [8];
    int                   len;
    int                   n_mismatch = 0;
    int                   comparisons = 0;
    int                   cyc = 0;

    data_space_paging #(.PROG_CYCLES(PC)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .req(req), .rsp(rsp), .hit(hit),
        .pm_addr(pm_addr), .pm_rdata(pm_rdata), .nv_busy_flag(nv_busy_flag));
    prog_mem_model pm_u (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

    initial forever #12.5 clock = ~clock;

    function automatic logic [7:0] pm_byte(input logic [11:0] x);
        return x[7:0] ^ {x[11:8], x[11:8]} ^ 8'h5A;
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic st(input logic [7:0] ad, input logic [7:0] w);
        @(posedge clock);
        req.addr <= ad;
        req.wdata <= w;
        req.wr <= 1'b1;
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    // Load, then check the answer arrives after the stated latency
    // A latency of 8 marks an address outside the block: no hit, no answer
    task automatic ld(input logic [7:0] ad, input int lat,
                      output logic [7:0] q);
        int n;
        @(posedge clock);
        req.addr <= ad;
        req.rd <= 1'b1;
        @(posedge clock);
        req.rd <= 1'b0;
        chk("hit", 8'(hit), 8'(lat < 8));
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (rsp.ack !== 1'b1 && n < 8);
        chk("ack latency", 8'(n), 8'(lat));
        q = rsp.rdata;
    endtask

    // Measure the busy span; zero when no cycle starts
    task automatic prog_len(output int l);
        int n;
        n = 0;
        l = 0;
        // Look only once the launching edge has settled
        do begin
            @(negedge clock);
            n++;
        end while (nv_busy_flag !== 1'b1 && n < 4);
        while (nv_busy_flag === 1'b1 && l < 4 * PC) begin
            @(negedge clock);
            l++;
        end
    endtask

    initial begin
        void'($urandom(85075));
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        ld(NV_CTL_ADDR, 1, d);
        chk("control idle", d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            base = 8'($urandom);
            // The image in base is updated before the register itself
            st(WIN_BASE_ADDR, base);
            a = (i == 0) ? WIN_LO : (i == 1) ? WIN_HI
                : WIN_LO | 8'($urandom & 63);
            e = pm_byte({base[5:0], a[5:0]});
            ld(a, 2, d);
            chk("window byte", d, e);
        end
        ld(WIN_BASE_ADDR, 1, d);
        chk("base read", d, 8'h00);
        ld(BANK_ADDR, 1, d);
        chk("bank read", d, 8'h00);
        ld(8'h80, 8, d);
        a = 8'($urandom & 63);
        st(BANK_ADDR, BANK_RAM1);
        st(a, 8'h5A);
        st(BANK_ADDR, BANK_RAM2);
        st(a, 8'hA5);
        ld(a, 1, d);
        chk("ram page 2", d, 8'hA5);
        st(BANK_ADDR, BANK_RAM1);
        ld(a, 1, d);
        chk("ram page 1", d, 8'h5A);
        st(BANK_ADDR, BANK_NONE);
        ld(a, 1, d);
        chk("no page", d, 8'h00);
        st(BANK_ADDR, BANK_NV0);
        for (int i = 0; i < 8; i++) begin
            row[i] = 8'($urandom);
            a = 8'h18 + 8'(i);
            st(NV_CTL_ADDR, 8'h01);
            st(a, row[i]);
            prog_len(len);
            chk("byte busy span", 8'(len), 8'(PC));
            ld(a, 1, d);
            chk("byte mode", d, row[i]);
        end
        st(NV_CTL_ADDR, 8'h01);
        st(8'h20, 8'h3C);
        ld(NV_CTL_ADDR, 1, d);
        chk("busy bit", d, 8'h02);
        ld(8'h18, 1, d);
        chk("read while busy", d, 8'h00);
        st(NV_CTL_ADDR, 8'h40);
        prog_len(len);
        ld(8'h20, 1, d);
        chk("after busy", d, 8'h3C);
        st(NV_CTL_ADDR, 8'h00);
        st(8'h20, 8'hC3);
        ld(8'h20, 1, d);
        chk("no enable", d, 8'h3C);
        st(NV_CTL_ADDR, 8'h40);
        ld(8'h20, 1, d);
        chk("standby read", d, 8'h00);
        st(NV_CTL_ADDR, 8'h01);
        st(NV_CTL_ADDR, 8'h09);
        prog_len(len);
        chk("start without row", 8'(len), 8'h00);
        st(NV_CTL_ADDR, 8'h05);
        st(8'h19, 8'h77);
        st(NV_CTL_ADDR, 8'h01); // Abandons the loaded row
        st(NV_CTL_ADDR, 8'h05);
        for (int i = 0; i < 4; i++) begin
            if (i == 1) continue;
            row[i] = 8'($urandom);
            st(8'h18 + 8'(i), row[i]);
        end
        st(8'h20, 8'h99);
        st(NV_CTL_ADDR, 8'h0D);
        prog_len(len);
        chk("row busy span", 8'(len), 8'(PC));
        for (int i = 0; i < 8; i++) begin
            ld(8'h18 + 8'(i), 1, d);
            chk("row byte", d, row[i]);
        end
        ld(8'h20, 1, d);
        chk("other row", d, 8'h3C);
        st(NV_CTL_ADDR, 8'h09);
        prog_len(len);
        chk("row mode cleared", 8'(len), 8'h00);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        ld(8'h1B, 1, d);
        chk("bank kept", d, row[3]);
        ld(WIN_LO, 2, d);
        chk("base kept", d, pm_byte({base[5:0], 6'h00}));
        print_verdict();
    end
endmodule
